// [rtl/bsmc_strobe.sv]
`timescale 1ns/100ps
package bsmc_pkg;
   localparam int CLK_PERIOD_NS = 10;
   localparam int STROBE_LOW_NS = 200;
   // least time: round up to whole cycles
   localparam int STROBE_CYCLES = (STROBE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int STROBE_CNT_W = 5;
   localparam logic [STROBE_CNT_W-1:0] STROBE_LAST = STROBE_CNT_W'(STROBE_CYCLES - 1);
   localparam int NUM_BLOCKS = 4;
   localparam int WORD_BITS = 8;
   localparam int BLOCK_ADDR_W = 12;
   localparam int BLOCK_WORDS = 4096;
   localparam int PAGE_W = 4;
   localparam int NUM_PAGES = 16;
   localparam logic [3:0] CS_N_RESET = 4'hF;
   localparam logic [3:0] WE_RESET = 4'h0;
   localparam logic [7:0] LATCH_RESET = 8'h00;
   typedef enum logic [0:0] {
      BSMC_ST_IDLE = 1'b0,
      BSMC_ST_TIMING = 1'b1
   } bsmc_strobe_st_t;
endpackage

////////////////////////////////////////////////////////////////////////////////
module bsmc_strobe (
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic trigger,
   output logic strobe_active
);
   typedef struct packed {
      bsmc_pkg::bsmc_strobe_st_t st;
      logic [bsmc_pkg::STROBE_CNT_W-1:0] cnt;
   } bsmc_strobe_state_t;

   bsmc_strobe_state_t state_reg;
   bsmc_strobe_state_t state_next;

   // one-shot is not retriggerable: a trigger while timing is ignored
   always_comb
   begin
      state_next = state_reg;
      unique case (state_reg.st)
         bsmc_pkg::BSMC_ST_IDLE:
         begin
            if (trigger)
            begin
               state_next.st = bsmc_pkg::BSMC_ST_TIMING;
               state_next.cnt = bsmc_pkg::STROBE_LAST;
            end
         end
         bsmc_pkg::BSMC_ST_TIMING:
         begin
            if (state_reg.cnt == '0)
               state_next.st = bsmc_pkg::BSMC_ST_IDLE;
            else
               state_next.cnt = state_reg.cnt - 1'b1;
         end
      endcase
   end

   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         state_reg.st <= bsmc_pkg::BSMC_ST_IDLE;
         state_reg.cnt <= '0;
      end
      else
         state_reg <= state_next;
   end

   assign strobe_active = (state_reg.st == bsmc_pkg::BSMC_ST_TIMING);

   chk_strobe_width: assert property (@(posedge ref_clk) disable iff (!reset_n)
      $rose(strobe_active) |-> ##19 strobe_active ##1 !strobe_active)
      else $error("timing strobe not 200 ns long");
endmodule

// [rtl/bsmc_top.sv]
// Summary of operation
// - four 4K blocks, each placed at any 4K page; no two alike.
// - each block is eight one-bit memories, one per data bit.
// - phase 1 with sync starts a 200 ns active-low timing strobe.
// - during strobe only the decoded block's select goes low.
// - read word latched when the timing strobe ends.
// - latched byte driven on data-in only with memory read and card selected.
// - any block hit gives card selected, qualifying reads and writes.
// - write command when memory write high and card selected; data unlatched.
// - write command also fires the timing strobe.
// - write enable to memories is active high; low means read.
// - protected block keeps write enable low; reads still work.
// - write source may come from the external conditional write line.
// - top four address bits decode to sixteen active-low page selects.
// - each block picks one of sixteen page selects.
// - decoder needs both enables low; one is the output-cycle status.
// - second enable tied active or taken from alternate bank line.
// - protect switch on means writable, off means protected.
`timescale 1ns/100ps
module bsmc_top (
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic phase1,
   input wire logic psync,
   input wire logic [15:0] addr,
   input wire logic [7:0] data_out_bus,
   input wire logic mwrite,
   input wire logic smemr,
   input wire logic sout,
   input wire logic conditional_write_line,
   input wire logic cond_write_select,
   input wire logic alternate_bank_enable_n,
   input wire logic alt_bank_mode,
   input wire logic [3:0] block_a_page,
   input wire logic [3:0] block_b_page,
   input wire logic [3:0] block_c_page,
   input wire logic [3:0] block_d_page,
   input wire logic [3:0] write_switch_on,
   output logic [3:0] block_cs_n,
   output logic [3:0] block_we,
   output logic [7:0] data_in_bus,
   output logic data_in_oe
);
   ////////////////////////////////////////////////////////////////////////////////
   typedef struct packed {
      logic [3:0] cs_n;
      logic [3:0] we;
      logic [7:0] latch;
      logic oe;
      logic strobe_prev;
      logic wr_cmd_prev;
   } bsmc_state_t;

   bsmc_state_t state_reg;
   bsmc_state_t state_next;

   logic mem_bit [0:bsmc_pkg::NUM_BLOCKS-1][0:bsmc_pkg::WORD_BITS-1][0:bsmc_pkg::BLOCK_WORDS-1];

   logic [15:0] page_sel_n;
   logic [3:0] block_hit;
   logic [3:0] page_cfg [0:3];
   logic decode_en2_n;
   logic card_sel;
   logic wr_src;
   logic wr_cmd;
   logic strobe_active;
   logic strobe_end;
   logic strobe_trigger;
   logic [1:0] hit_idx;
   logic [7:0] rd_word;
   logic [bsmc_pkg::BLOCK_ADDR_W-1:0] addr_lo;

   ////////////////////////////////////////////////////////////////////////////////
   // one-hot active-low page decode, all high when disabled
   function automatic logic [15:0] page_decode_n(input logic [3:0] page, input logic en);
      logic [15:0] sel;
      sel = 16'hFFFF;
      if (en)
         sel[page] = 1'b0;
      return sel;
   endfunction

   function automatic logic [1:0] hit_encode(input logic [3:0] hit);
      logic [1:0] idx;
      idx = 2'h0;
      for (int i = bsmc_pkg::NUM_BLOCKS - 1; i >= 0; i--)
         if (hit[i])
            idx = 2'(i);
      return idx;
   endfunction

   assign page_cfg[0] = block_a_page;
   assign page_cfg[1] = block_b_page;
   assign page_cfg[2] = block_c_page;
   assign page_cfg[3] = block_d_page;
   assign addr_lo = addr[bsmc_pkg::BLOCK_ADDR_W-1:0];

   // second enable: tied low in standard mode, alternate bank line otherwise
   assign decode_en2_n = alt_bank_mode ? alternate_bank_enable_n : 1'b0;
   assign page_sel_n = page_decode_n(addr[15:12], !sout && !decode_en2_n);

   // two blocks on one page would both hit; placement must keep them apart
   always_comb
   begin
      for (int i = 0; i < bsmc_pkg::NUM_BLOCKS; i++)
         block_hit[i] = !page_sel_n[page_cfg[i]];
   end

   assign card_sel = |block_hit;
   assign wr_src = cond_write_select ? conditional_write_line : mwrite;
   assign wr_cmd = wr_src && card_sel;
   assign hit_idx = hit_encode(block_hit);

   always_comb
   begin
      for (int b = 0; b < bsmc_pkg::WORD_BITS; b++)
         rd_word[b] = mem_bit[hit_idx][b][addr_lo];
   end

   // write command edge starts the strobe as a read would, unless it is already timing
   assign strobe_trigger = (phase1 && psync) || (wr_cmd && !state_reg.wr_cmd_prev);
   assign strobe_end = state_reg.strobe_prev && !strobe_active;

   bsmc_strobe u_strobe (
      .ref_clk(ref_clk),
      .reset_n(reset_n),
      .trigger(strobe_trigger),
      .strobe_active(strobe_active)
   );

   ////////////////////////////////////////////////////////////////////////////////
   always_comb
   begin
      state_next = state_reg;
      state_next.strobe_prev = strobe_active;
      state_next.wr_cmd_prev = wr_cmd;
      state_next.cs_n = ~(block_hit & {4{strobe_active}});
      // open switch holds the block's enable low
      state_next.we = {4{wr_cmd}} & write_switch_on;
      // capture late so memory outputs have settled
      if (strobe_end && card_sel)
         state_next.latch = rd_word;
      state_next.oe = smemr && card_sel;
   end

   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         state_reg.cs_n <= bsmc_pkg::CS_N_RESET;
         state_reg.we <= bsmc_pkg::WE_RESET;
         state_reg.latch <= bsmc_pkg::LATCH_RESET;
         state_reg.oe <= 1'b0;
         state_reg.strobe_prev <= 1'b0;
         state_reg.wr_cmd_prev <= 1'b0;
      end
      else
         state_reg <= state_next;
   end

   // write data is not latched: taken straight from the data-out bus
   always_ff @(posedge ref_clk)
   begin
      for (int i = 0; i < bsmc_pkg::NUM_BLOCKS; i++)
         if (!state_reg.cs_n[i] && state_reg.we[i])
            for (int b = 0; b < bsmc_pkg::WORD_BITS; b++)
               mem_bit[i][b][addr_lo] <= data_out_bus[b];
   end

   assign block_cs_n = state_reg.cs_n;
   assign block_we = state_reg.we;
   assign data_in_bus = state_reg.latch;
   assign data_in_oe = state_reg.oe;

   ////////////////////////////////////////////////////////////////////////////////
   sequence seq_sync_idle;
      !strobe_active && phase1 && psync;
   endsequence

   sequence seq_write_rise;
      wr_cmd && !state_reg.wr_cmd_prev && !strobe_active;
   endsequence

   sequence seq_latch_edge;
      strobe_end && card_sel;
   endsequence

   chk_cs_onehot: assert property (@(posedge ref_clk) disable iff (!reset_n)
      $onehot0(~block_cs_n))
      else $error("more than one block selected");

   chk_cs_strobe: assert property (@(posedge ref_clk) disable iff (!reset_n)
      !strobe_active |=> (block_cs_n == 4'hF))
      else $error("block select low outside strobe");

   chk_sync_start: assert property (@(posedge ref_clk) disable iff (!reset_n)
      seq_sync_idle |=> strobe_active)
      else $error("strobe not started by phase 1 and sync");

   chk_write_trigger: assert property (@(posedge ref_clk) disable iff (!reset_n)
      seq_write_rise |=> strobe_active ##1 (block_cs_n == ~$past(block_hit)))
      else $error("write command did not fire strobe");

   chk_latch_capture: assert property (@(posedge ref_clk) disable iff (!reset_n)
      seq_latch_edge |=> (data_in_bus == $past(rd_word)))
      else $error("read word not latched at strobe end");

   chk_read_drive: assert property (@(posedge ref_clk) disable iff (!reset_n)
      (smemr && card_sel) |=> data_in_oe)
      else $error("data-in not driven on selected read");

   chk_bus_release: assert property (@(posedge ref_clk) disable iff (!reset_n)
      !(smemr && card_sel) |=> !data_in_oe)
      else $error("data-in driven while not reading");

   chk_we_command: assert property (@(posedge ref_clk) disable iff (!reset_n)
      wr_cmd |=> (block_we == $past(write_switch_on)))
      else $error("write enable does not follow write command");

   chk_protect_hold: assert property (@(posedge ref_clk) disable iff (!reset_n)
      1'b1 |=> ((block_we & ~$past(write_switch_on)) == 4'h0))
      else $error("protected block write enabled");

   chk_output_cycle: assert property (@(posedge ref_clk) disable iff (!reset_n)
      sout |-> !card_sel)
      else $error("card selected during output cycle");

   chk_alt_bank: assert property (@(posedge ref_clk) disable iff (!reset_n)
      (alt_bank_mode && alternate_bank_enable_n) |-> !card_sel)
      else $error("card responds without alternate bank enable");

   chk_latch_hold: assert property (@(posedge ref_clk) disable iff (!reset_n)
      !(strobe_end && card_sel) |=> $stable(data_in_bus))
      else $error("read latch changed outside strobe end");

   chk_we_idle: assert property (@(posedge ref_clk) disable iff (!reset_n)
      !wr_cmd |=> (block_we == 4'h0))
      else $error("write enable without write command");

   chk_we_mwrite_src: assert property (@(posedge ref_clk) disable iff (!reset_n)
      (!cond_write_select && !mwrite) |-> !wr_cmd)
      else $error("write command without memory write");

   chk_we_cond_src: assert property (@(posedge ref_clk) disable iff (!reset_n)
      (cond_write_select && !conditional_write_line) |-> !wr_cmd)
      else $error("write command without conditional write line");

   chk_we_unselected: assert property (@(posedge ref_clk) disable iff (!reset_n)
      !card_sel |=> (block_we == 4'h0))
      else $error("write enable while card not selected");

   chk_oe_unselected: assert property (@(posedge ref_clk) disable iff (!reset_n)
      !card_sel |=> !data_in_oe)
      else $error("data-in driven while card not selected");

   chk_page_onehot: assert property (@(posedge ref_clk) disable iff (!reset_n)
      $onehot0(~page_sel_n))
      else $error("more than one page select low");

   chk_page_decode: assert property (@(posedge ref_clk) disable iff (!reset_n)
      (!sout && !decode_en2_n) |-> (page_sel_n == ~(16'h0001 << addr[15:12])))
      else $error("page select does not match address");

   chk_hit_page: assert property (@(posedge ref_clk) disable iff (!reset_n)
      card_sel |-> (page_cfg[hit_idx] == addr[15:12]))
      else $error("selected block not placed at addressed page");

   chk_block_a_hit: assert property (@(posedge ref_clk) disable iff (!reset_n)
      (!sout && !decode_en2_n && (block_a_page == addr[15:12])) |-> block_hit[0])
      else $error("first block missed at its page");

   chk_block_d_hit: assert property (@(posedge ref_clk) disable iff (!reset_n)
      (!sout && !decode_en2_n && (block_d_page == addr[15:12])) |-> block_hit[3])
      else $error("last block missed at its page");

   chk_std_bank: assert property (@(posedge ref_clk) disable iff (!reset_n)
      !alt_bank_mode |-> !decode_en2_n)
      else $error("second enable not active in standard mode");

   chk_sout_release: assert property (@(posedge ref_clk) disable iff (!reset_n)
      sout |=> (!data_in_oe && (block_we == 4'h0)))
      else $error("card active after output cycle status");

   chk_cs_hit: assert property (@(posedge ref_clk) disable iff (!reset_n)
      (strobe_active && card_sel) |=> (block_cs_n == ~$past(block_hit)))
      else $error("decoded block not selected during strobe");

   chk_cs_miss: assert property (@(posedge ref_clk) disable iff (!reset_n)
      !card_sel |=> (block_cs_n == 4'hF))
      else $error("block selected while card not selected");

   chk_protect_open: assert property (@(posedge ref_clk) disable iff (!reset_n)
      (wr_cmd && write_switch_on[0]) |=> block_we[0])
      else $error("writable block not write enabled");

   chk_read_no_we: assert property (@(posedge ref_clk) disable iff (!reset_n)
      (smemr && !mwrite && !cond_write_select) |=> (block_we == 4'h0))
      else $error("write enable during memory read");
endmodule

// [verif/bsmc_bus_master.sv]
`timescale 1ns/100ps
module bsmc_bus_master (
   input wire logic ref_clk,
   output logic phase1,
   output logic psync,
   output logic [15:0] addr,
   output logic [7:0] data_out_bus,
   output logic mwrite,
   output logic smemr,
   output logic sout,
   output logic conditional_write_line,
   output logic alternate_bank_enable_n
);
   initial
   begin
      phase1 = 1'b0;
      psync = 1'b0;
      addr = 16'h0000;
      data_out_bus = 8'h00;
      mwrite = 1'b0;
      smemr = 1'b0;
      sout = 1'b0;
      conditional_write_line = 1'b0;
      alternate_bank_enable_n = 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // sync pulse for one edge; status, address and data held until end_cycle
   task automatic begin_cycle(input logic wr, input logic [15:0] a, input logic [7:0] d, input logic so,
      input logic cw, input logic abx_n);
      @(posedge ref_clk);
      #1;
      addr = a;
      data_out_bus = d;
      mwrite = wr;
      smemr = !wr;
      sout = so;
      conditional_write_line = cw & wr;
      alternate_bank_enable_n = abx_n;
      phase1 = 1'b1;
      psync = 1'b1;
      @(posedge ref_clk);
      #1;
      phase1 = 1'b0;
      psync = 1'b0;
   endtask

   task automatic end_cycle();
      mwrite = 1'b0;
      smemr = 1'b0;
      conditional_write_line = 1'b0;
      // released lines must not keep their last value
      addr = ~addr;
      data_out_bus = ~data_out_bus;
   endtask
endmodule

// [verif/testbench.sv]
`timescale 1ns/100ps
module testbench;
   logic ref_clk, reset_n, phase1, psync, mwrite, smemr, sout, cwl, abx_n;
   logic cond_write_select, alt_bank_mode, data_in_oe;
   logic [15:0] addr;
   logic [7:0] data_out_bus, data_in_bus;
   logic [3:0] pg [4];
   logic [3:0] write_switch_on, block_cs_n, block_we;
   logic [7:0] mem [4][4096];
   logic [15:0] al [8];
   logic [31:0] r;
   int fail_count, num_checks;

   bsmc_bus_master bm (.ref_clk(ref_clk), .phase1(phase1), .psync(psync), .addr(addr),
      .data_out_bus(data_out_bus), .mwrite(mwrite), .smemr(smemr), .sout(sout),
      .conditional_write_line(cwl), .alternate_bank_enable_n(abx_n));
   bsmc_top uut (.ref_clk(ref_clk), .reset_n(reset_n), .phase1(phase1), .psync(psync), .addr(addr),
      .data_out_bus(data_out_bus), .mwrite(mwrite), .smemr(smemr), .sout(sout),
      .conditional_write_line(cwl), .cond_write_select(cond_write_select),
      .alternate_bank_enable_n(abx_n), .alt_bank_mode(alt_bank_mode), .block_a_page(pg[0]),
      .block_b_page(pg[1]), .block_c_page(pg[2]), .block_d_page(pg[3]),
      .write_switch_on(write_switch_on), .block_cs_n(block_cs_n), .block_we(block_we),
      .data_in_bus(data_in_bus), .data_in_oe(data_in_oe));

   ////////////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic print_verdict();
      $display("checks %0d failures %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   // one machine cycle against the model; memory model updated only after the compare
   task automatic access(input logic wr, input logic [15:0] a, input logic [7:0] d, input logic so,
      input logic cw, input logic ab);
      int h;
      logic wcmd;
      logic [3:0] cs_exp, we_exp;
      h = -1;
      for (int b = 0; b < 4; b++)
         if (pg[b] == a[15:12] && !so && !(alt_bank_mode && ab))
            h = b;
      wcmd = cond_write_select ? (cw & wr) : wr;
      cs_exp = (h < 0) ? 4'hF : ~(4'h1 << h);
      we_exp = (h >= 0 && wcmd) ? write_switch_on : 4'h0;
      bm.begin_cycle(wr, a, d, so, cw, ab);
      repeat (10) @(posedge ref_clk);
      #1;
      check(block_cs_n, cs_exp);
      check(block_we, we_exp);
      check(data_in_oe, !wr && h >= 0);
      repeat (10) @(posedge ref_clk);
      #1;
      check(block_cs_n, cs_exp);
      @(posedge ref_clk);
      #1;
      check(block_cs_n, 4'hF);
      if (h >= 0 && !wr)
         check(data_in_bus, mem[h][a[11:0]]);
      if (h >= 0 && wcmd && write_switch_on[h])
         mem[h][a[11:0]] = d;
      bm.end_cycle();
      repeat (2) @(posedge ref_clk);
      #1;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end

   initial
   begin
      #100000;
      fail_count++;
      print_verdict();
   end

   initial
   begin
      reset_n = 1'b0;
      cond_write_select = 1'b0;
      alt_bank_mode = 1'b0;
      write_switch_on = 4'hF;
      void'($urandom(90));
      r = $urandom;
      // spacing of four keeps the pages distinct and leaves gaps to miss
      for (int b = 0; b < 4; b++)
         pg[b] = r[3:0] + 4'(4 * b);
      for (int i = 0; i < 8; i++)
         al[i] = {pg[i % 4], 12'($urandom_range(4095))};
      repeat (4) @(posedge ref_clk);
      #1;
      reset_n = 1'b1;
      for (int i = 0; i < 8; i++)
         access(1'b1, al[i], 8'($urandom), 1'b0, 1'b0, 1'b0);
      write_switch_on = 4'($urandom);
      for (int i = 0; i < 8; i++)
         access(1'b1, al[i], 8'($urandom), 1'b0, 1'b0, 1'b0);
      for (int i = 0; i < 8; i++)
         access(1'b0, al[i], 8'h00, 1'b0, 1'b0, 1'b0);
      for (int m = 0; m < 4; m++)
      begin
         cond_write_select = m[1];
         alt_bank_mode = m[0];
         for (int i = 0; i < 8; i++)
         begin
            r = $urandom;
            write_switch_on = r[15:12];
            access(1'b1, al[i], r[7:0], r[8] & r[9], r[10], r[11]);
            access(1'b0, al[i], 8'h00, 1'b0, 1'b0, r[16]);
         end
      end
      access(1'b1, {pg[0] + 4'h1, 12'h000}, 8'h5A, 1'b0, 1'b1, 1'b0);
      access(1'b0, {pg[0] + 4'h1, 12'h000}, 8'h00, 1'b0, 1'b0, 1'b0);
      print_verdict();
   end
endmodule
